// ---- src/wdt_pkg.sv ----
// Package holding constants of the watchdog timer block.
package wdt_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Byte offsets of the software-visible registers.
  localparam logic [3:0] WDT_ADDR_CONTROL = 4'h0;   // Protected watchdog control register.
  localparam logic [3:0] WDT_ADDR_IRQ_STAT = 4'h1;  // Sticky event status, cleared on read.
  localparam logic [3:0] WDT_ADDR_IRQ_MASK = 4'h2;  // Event mask, same layout as status.
  localparam logic [3:0] WDT_ADDR_COUNT_LO = 4'h3;  // Low byte of the running counter.
  localparam logic [3:0] WDT_ADDR_COUNT_HI = 4'h4;  // High byte of the running counter.

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int WDT_PRE_MSB    = 7;  // Timeout select field, upper bit.
  localparam int WDT_PRE_LSB    = 4;  // Timeout select field, lower bit.
  localparam int WDT_BIT_RESP   = 3;  // Timeout response select bit.
  localparam int WDT_BIT_FLAG   = 2;  // Timeout flag bit.
  localparam int WDT_BIT_RUN    = 1;  // Watchdog run bit.
  localparam int WDT_BIT_UNLOCK = 0;  // Write unlock bit.

  // Reset values of the control fields.
  localparam logic [3:0] WDT_PRE_RST    = 4'h7;
  localparam logic       WDT_RESP_RST   = 1'b0;
  localparam logic       WDT_FLAG_RST   = 1'b0;
  localparam logic       WDT_RUN_RST    = 1'b1;
  localparam logic       WDT_UNLOCK_RST = 1'b0;

  // Special timeout select codes.
  localparam logic [3:0] WDT_PRE_AUTO_RESET = 4'h8;  // Immediate automatic reset.
  localparam logic [3:0] WDT_PRE_DL_RESET   = 4'h9;  // Reset into serial download.
  localparam logic [3:0] WDT_PRE_MAX_TIMED  = 4'h7;  // Largest timed code.

  // ==========================================================================
  // Interrupt status bit positions
  // ==========================================================================
  localparam int WDT_EV_TIMEOUT = 0;  // A timed period expired.
  localparam int WDT_EV_RESET   = 1;  // The block requested a system or download reset.
  localparam int WDT_EV_DISABLE = 2;  // Hardware disabled the watchdog.
  localparam int WDT_EV_WIDTH   = 3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int WDT_MCLK_HZ    = 50000000;  // System clock rate.
  localparam int WDT_INCLK_HZ   = 32768;     // Watchdog input clock rate.
  localparam int WDT_BASE_SHIFT = 9;         // Timeout is 2^pre times 2^9 input periods.
  localparam int WDT_CNT_WIDTH  = 16;        // Width of the watchdog counter.

  // Reset request pulse length in system clocks.
  localparam logic [3:0] WDT_RST_PULSE_CYC = 4'h4;

endpackage

// ---- src/wdt_ctrl.sv ----
// Watchdog timer with protected control register and event interrupts.
`timescale 1ns/10ps
module wdt_ctrl #(
  parameter int P_CNT_WIDTH = wdt_pkg::WDT_CNT_WIDTH  // Counter width.
) (
  input  wire logic       i_mclk,              // System clock, 50 MHz.
  input  wire logic       i_rst,               // External hardware reset, asynchronous, high.
  input  wire logic       i_input_clock_tick,  // One-cycle pulse per 32.768 kHz input period.
  input  wire logic       i_instr_done,        // One-cycle pulse when an instruction retires.
  input  wire logic       i_supply_monitor_event,  // Supply-monitor interrupt pulse.
  input  wire logic       i_clock_lock_event,  // Clock-lock interrupt pulse.
  input  wire logic [3:0] i_addr,              // Register address.
  input  wire logic [7:0] i_wdata,             // Register write data.
  input  wire logic       i_wr,                // Write strobe.
  input  wire logic       i_rd,                // Read strobe.
  output logic      [7:0] o_rdata,             // Read data, valid the cycle after i_rd.
  output logic            o_sys_reset,         // System reset request pulse.
  output logic            o_download_reset,    // Serial download reset request pulse.
  output logic            o_wdt_irq,           // Watchdog interrupt request to the core.
  output logic            o_irq                // Block event interrupt, level.
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [3:0]             pre_reg,    pre_next;     // Timeout select field.
  logic                   resp_reg,   resp_next;    // Timeout response select.
  logic                   flag_reg,   flag_next;    // Sticky timeout flag.
  logic                   run_reg,    run_next;     // Watchdog running.
  logic                   unlock_reg, unlock_next;  // Write unlock armed.
  logic                   armed_reg,  armed_next;   // Unlock survives one more instruction.
  logic [P_CNT_WIDTH-1:0] cnt_reg,    cnt_next;     // Watchdog counter.
  logic [3:0]             rpulse_reg, rpulse_next;  // Reset pulse length counter.
  logic                   rkind_reg,  rkind_next;   // Reset kind: 1 means download reset.
  logic [wdt_pkg::WDT_EV_WIDTH-1:0] stat_reg, stat_next;  // Sticky event status.
  logic [wdt_pkg::WDT_EV_WIDTH-1:0] mask_reg, mask_next;  // Event mask.
  logic [7:0]             rdata_reg,  rdata_next;   // Registered read data.
  logic                   ctrl_wr;                  // Write to the control register.
  logic                   ctrl_ok;                  // Control write that is accepted.
  logic                   expire;                   // Timed period has elapsed.
  logic                   do_reset;                 // Start a reset request.
  logic                   do_dl;                    // The reset is a download reset.
  logic [wdt_pkg::WDT_EV_WIDTH-1:0] ev;              // Events of this cycle.
  logic [7:0]             ctrl_view;                // Control register read image.

  // Terminal count for a timed code: 2^pre * 2^9 input periods.
  function automatic logic [P_CNT_WIDTH:0] term_count(input logic [3:0] pre);
    logic [P_CNT_WIDTH:0] t;
    t = '0;
    t[wdt_pkg::WDT_BASE_SHIFT + pre[2:0]] = 1'b1;
    return t;
  endfunction

  // ==========================================================================
  // Decode
  // ==========================================================================
  // A write strobe to the control address; only accepted when unlocked.
  always_comb begin
    ctrl_wr = i_wr && (i_addr == wdt_pkg::WDT_ADDR_CONTROL);
    ctrl_ok = ctrl_wr && unlock_reg;
    ctrl_view = {pre_reg, resp_reg, flag_reg, run_reg, unlock_reg};
  end

  // ==========================================================================
  // Control register and counter
  // ==========================================================================
  // Next-state logic of the protected control register and the counter.
  always_comb begin
    pre_next    = pre_reg;
    resp_next   = resp_reg;
    flag_next   = flag_reg;
    run_next    = run_reg;
    unlock_next = unlock_reg;
    armed_next  = armed_reg;
    cnt_next    = cnt_reg;
    expire      = 1'b0;
    do_reset    = 1'b0;
    do_dl       = 1'b0;

    // Unlock window: set by a write with only the unlock bit honoured, then it
    // lasts through exactly one further instruction.
    if (unlock_reg && i_instr_done) begin
      if (armed_reg) begin
        armed_next = 1'b0;  // The unlocking instruction itself retires.
      end else begin
        unlock_next = 1'b0;
      end
    end

    if (ctrl_ok) begin
      // Accepted write: fields load except the flag, which only clears; unlock is consumed.
      pre_next    = i_wdata[wdt_pkg::WDT_PRE_MSB:wdt_pkg::WDT_PRE_LSB];
      resp_next   = i_wdata[wdt_pkg::WDT_BIT_RESP];
      run_next    = i_wdata[wdt_pkg::WDT_BIT_RUN];
      unlock_next = 1'b0;
      armed_next  = 1'b0;
      if (!i_wdata[wdt_pkg::WDT_BIT_FLAG]) begin
        flag_next = 1'b0;
      end
      if (i_wdata[wdt_pkg::WDT_BIT_RUN]) begin
        cnt_next = '0;
      end
    end else if (ctrl_wr && i_wdata[wdt_pkg::WDT_BIT_UNLOCK]) begin
      // Locked write: only the unlock bit takes, the rest is ignored.
      unlock_next = 1'b1;
      armed_next  = 1'b1;
    end

    // Counting and expiry while running and idle of reset.
    if (run_reg && !ctrl_ok && rpulse_reg == '0) begin
      if (pre_reg == wdt_pkg::WDT_PRE_AUTO_RESET) begin
        do_reset = 1'b1;
        run_next = 1'b0;
      end else if (pre_reg == wdt_pkg::WDT_PRE_DL_RESET) begin
        do_reset = 1'b1;
        do_dl    = 1'b1;
        run_next = 1'b0;
      end else if (pre_reg <= wdt_pkg::WDT_PRE_MAX_TIMED && i_input_clock_tick) begin
        if ({1'b0, cnt_reg} + 1'b1 >= term_count(pre_reg)) begin
          expire    = 1'b1;
          flag_next = 1'b1;
          cnt_next  = '0;
          if (!resp_reg) begin
            do_reset = 1'b1;
            run_next = 1'b0;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    end

    // Supply-monitor and clock-lock events stop the watchdog.
    if (i_supply_monitor_event || i_clock_lock_event) begin
      run_next = 1'b0;
    end
  end

  // Registers of the control group; the flag clears on the external reset or on an accepted control write with the flag bit at zero.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg    <= wdt_pkg::WDT_PRE_RST;
      resp_reg   <= wdt_pkg::WDT_RESP_RST;
      flag_reg   <= wdt_pkg::WDT_FLAG_RST;
      run_reg    <= wdt_pkg::WDT_RUN_RST;
      unlock_reg <= wdt_pkg::WDT_UNLOCK_RST;
      armed_reg  <= 1'b0;
      cnt_reg    <= '0;
    end else begin
      pre_reg    <= pre_next;
      resp_reg   <= resp_next;
      flag_reg   <= flag_next;
      run_reg    <= run_next;
      unlock_reg <= unlock_next;
      armed_reg  <= armed_next;
      cnt_reg    <= cnt_next;
    end
  end

  // ==========================================================================
  // Reset request generator
  // ==========================================================================
  // A reset request is a fixed-length pulse so the core reset logic sees it
  // even when it samples slowly; the watchdog itself does not reset here.
  always_comb begin
    rpulse_next = rpulse_reg;
    rkind_next  = rkind_reg;
    if (do_reset) begin
      rpulse_next = wdt_pkg::WDT_RST_PULSE_CYC;
      rkind_next  = do_dl;
    end else if (rpulse_reg != '0) begin
      rpulse_next = rpulse_reg - 1'b1;
    end
  end

  // Registers of the reset request.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rpulse_reg <= '0;
      rkind_reg  <= 1'b0;
    end else begin
      rpulse_reg <= rpulse_next;
      rkind_reg  <= rkind_next;
    end
  end

  assign o_sys_reset      = (rpulse_reg != '0) && !rkind_reg;
  assign o_download_reset = (rpulse_reg != '0) && rkind_reg;
  // Held while the flag is set in interrupt response mode.
  assign o_wdt_irq        = resp_reg && flag_reg;

  // ==========================================================================
  // Event status, mask and read port
  // ==========================================================================
  // Status bits set on events; a status read clears them, but a new event in
  // the same cycle wins so nothing is lost.
  always_comb begin
    ev = '0;
    ev[wdt_pkg::WDT_EV_TIMEOUT] = expire;
    ev[wdt_pkg::WDT_EV_RESET]   = do_reset;
    ev[wdt_pkg::WDT_EV_DISABLE] = run_reg && (i_supply_monitor_event || i_clock_lock_event);
    stat_next = stat_reg;
    if (i_rd && i_addr == wdt_pkg::WDT_ADDR_IRQ_STAT) begin
      stat_next = '0;
    end
    stat_next = stat_next | ev;
    mask_next = mask_reg;
    if (i_wr && i_addr == wdt_pkg::WDT_ADDR_IRQ_MASK) begin
      mask_next = i_wdata[wdt_pkg::WDT_EV_WIDTH-1:0];
    end
    rdata_next = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        wdt_pkg::WDT_ADDR_CONTROL:  rdata_next = ctrl_view;
        wdt_pkg::WDT_ADDR_IRQ_STAT: rdata_next = {5'h00, stat_reg};
        wdt_pkg::WDT_ADDR_IRQ_MASK: rdata_next = {5'h00, mask_reg};
        wdt_pkg::WDT_ADDR_COUNT_LO: rdata_next = cnt_reg[7:0];
        wdt_pkg::WDT_ADDR_COUNT_HI: rdata_next = cnt_reg[P_CNT_WIDTH-1:8];
        default:                    rdata_next = 8'h00;  // Unmapped reads as zero.
      endcase
    end
  end

  // Registers of the status, mask and read data.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      stat_reg  <= '0;
      mask_reg  <= '0;
      rdata_reg <= 8'h00;
    end else begin
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq   = |(stat_reg & mask_reg);

endmodule

// ---- tb/wdt_ctrl_monitor.sv ----
// Port-level checker of the watchdog block.
`timescale 1ns/10ps
module wdt_ctrl_monitor #(
  parameter int P_CNT_WIDTH = 16  // Counter width, handed on by the bind.
) (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_input_clock_tick,
  input wire logic       i_instr_done,
  input wire logic       i_supply_monitor_event,
  input wire logic       i_clock_lock_event,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_sys_reset,
  input wire logic       o_download_reset,
  input wire logic       o_wdt_irq,
  input wire logic       o_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // Relations between the ports
  // ==========================================================================
  // Read data only stand in the cycle after a read strobe.
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside answer cycle");
  unmapped_rd_a: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  sysrst_len_a: assert property ($rose(o_sys_reset) |-> o_sys_reset [*4] ##1 !o_sys_reset)
    else $error("system reset pulse length wrong");
  dlrst_len_a: assert property ($rose(o_download_reset) |-> o_download_reset [*4] ##1 !o_download_reset)
    else $error("download reset pulse length wrong");
  rst_excl_a: assert property (!(o_sys_reset && o_download_reset)) else $error("both reset kinds at once");
  // A set flag only drops through a register write, never by itself.
  wdtirq_hold_a: assert property ($fell(o_wdt_irq) |-> $past(i_wr)) else $error("watchdog irq dropped");
  wdtirq_cause_a: assert property ($rose(o_wdt_irq) |-> $past(i_input_clock_tick) || $past(i_wr))
    else $error("watchdog irq without cause");
  irq_mode_a: assert property ($rose(o_wdt_irq) |-> !o_sys_reset ##1 !o_sys_reset ##1 !o_sys_reset)
    else $error("reset issued in interrupt mode");
  // A timed expiry starts the pulse on the tick edge itself, so the tick is one sample back.
  sysrst_cause_a: assert property ($rose(o_sys_reset) |-> $past(i_input_clock_tick) || $past(i_wr)
    || $past(i_wr, 2) || $past(i_wr, 3)) else $error("system reset without cause");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_rd) || $past(i_wr)) else $error("event irq dropped");
  sysrst_c: cover property ($rose(o_sys_reset));
  dlrst_c: cover property ($rose(o_download_reset));
  wdtirq_c: cover property ($rose(o_wdt_irq));
endmodule

// ---- tb/wdt_core_model.sv ----
// Behavioural model of the core side: input clock ticks and reset capture.
`timescale 1ns/10ps
module wdt_core_model (
  input  wire logic       i_mclk,
  input  wire logic       i_sys_reset,
  input  wire logic       i_download_reset,
  output logic            o_tick,
  output logic      [7:0] o_rst_cnt,
  output logic      [7:0] o_dl_cnt
);
  logic sys_d = 1'b0;  // Last sampled system reset request.
  logic dl_d  = 1'b0;  // Last sampled download reset request.
  initial begin
    o_tick = 1'b0;
    o_rst_cnt = 8'h00;
    o_dl_cnt = 8'h00;
  end
  // ==========================================================================
  // Ticks and reset capture
  // ==========================================================================
  // One input period is squeezed to two system clocks so timeouts stay short.
  // The counts survive every reset: the core never feeds a request back to i_rst.
  always @(posedge i_mclk) begin
    o_tick <= ~o_tick;
    sys_d <= i_sys_reset;
    dl_d <= i_download_reset;
    if (i_sys_reset && !sys_d) begin
      o_rst_cnt <= o_rst_cnt + 8'h01;
    end
    if (i_download_reset && !dl_d) begin
      o_dl_cnt <= o_dl_cnt + 8'h01;
    end
  end
endmodule

// ---- tb/wdt_ctrl_tb.sv ----
// Self-checking testbench of the watchdog block.
`timescale 1ns/10ps
module wdt_ctrl_tb;
  logic       mclk = 1'b0, rst = 1'b1, done = 1'b0, sup = 1'b0, lock = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, rst_cnt, dl_cnt;
  logic       tick, sys_rst, dl_rst, wdt_irq, irq;
  int         error_cnt = 0, num_checks = 0;
  wdt_ctrl i_wdt_ctrl (.i_mclk(mclk), .i_rst(rst), .i_input_clock_tick(tick), .i_instr_done(done),
    .i_supply_monitor_event(sup), .i_clock_lock_event(lock), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_sys_reset(sys_rst), .o_download_reset(dl_rst), .o_wdt_irq(wdt_irq), .o_irq(irq));
  wdt_core_model i_wdt_core_model (.i_mclk(mclk), .i_sys_reset(sys_rst), .i_download_reset(dl_rst),
    .o_tick(tick), .o_rst_cnt(rst_cnt), .o_dl_cnt(dl_cnt));
  initial forever #10 mclk = ~mclk;
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus cycle; every signal changes right after the rising edge.
  task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d, input logic dn);
    @(posedge mclk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    done <= dn;
  endtask
  task rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00, 1'b0);
    bus(1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    #1;
    chk(nm, rdata, exp);
  endtask
  // Unlock, then the very next instruction writes; only codes 0 to 9 are used.
  task ctl_wr(input logic [7:0] d);
    bus(1'b1, 1'b0, 4'h0, 8'h01, 1'b1);
    bus(1'b1, 1'b0, 4'h0, d, 1'b1);
    bus(1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
  endtask
  task ticks(input int n);
    repeat (n) @(posedge tick);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_reset;
    rd_chk("ctrl reset", 4'h0, 8'h72);
    rd_chk("unmapped", 4'hf, 8'h00);
    $display("test reset values done");
  endtask
  // Writes without a live unlock, or after it expired, change nothing.
  task t_lock;
    bus(1'b1, 1'b0, 4'h0, 8'h00, 1'b1);
    bus(1'b1, 1'b0, 4'hf, 8'hff, 1'b0);
    bus(1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    rd_chk("ctrl locked", 4'h0, 8'h72);
    bus(1'b1, 1'b0, 4'h0, 8'h01, 1'b1);
    // Each instruction retires in the cycle after its bus access: first the unlock, then a plain one.
    bus(1'b0, 1'b0, 4'h0, 8'h00, 1'b1);
    bus(1'b0, 1'b0, 4'h0, 8'h00, 1'b1);
    bus(1'b1, 1'b0, 4'h0, 8'h00, 1'b1);
    bus(1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    rd_chk("ctrl expired", 4'h0, 8'h72);
    $display("test write lock done");
  endtask
  task t_irq_mode;
    ctl_wr(8'h0a);
    ticks(400);
    ctl_wr(8'h0a);
    ticks(400);
    chk("restart", wdt_irq, 1'b0);
    ticks(150);
    chk("wdt irq", wdt_irq, 1'b1);
    chk("no reset", rst_cnt, 8'h00);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, 1'b0, 4'h2, 8'h01, 1'b0);
    bus(1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    #1;
    chk("irq unmasked", irq, 1'b1);
    rd_chk("status", 4'h1, 8'h01);
    chk("irq cleared", irq, 1'b0);
    rd_chk("ctrl flag", 4'h0, 8'h0e);
    chk("irq holds", wdt_irq, 1'b1);
    ctl_wr(8'h08);
    rd_chk("flag cleared", 4'h0, 8'h08);
    chk("irq dropped", wdt_irq, 1'b0);
    $display("test interrupt mode done");
  endtask
  task t_reset_mode;
    ctl_wr(8'h02);
    ticks(520);
    chk("reset issued", rst_cnt, 8'h01);
    rd_chk("ctrl after wdt reset", 4'h0, 8'h04);
    rd_chk("status reset", 4'h1, 8'h03);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk("ctrl after hw reset", 4'h0, 8'h72);
    ctl_wr(8'h82);
    ticks(8);
    chk("auto reset", rst_cnt, 8'h02);
    ctl_wr(8'h92);
    ticks(8);
    chk("download reset", dl_cnt, 8'h01);
    chk("no sys reset", rst_cnt, 8'h02);
    $display("test reset mode done");
  endtask
  task t_disable;
    for (int k = 0; k < 2; k++) begin
      ctl_wr(8'h02);
      rd_chk("running", 4'h0, 8'h02);
      @(posedge mclk);
      sup <= (k == 0);
      lock <= (k == 1);
      @(posedge mclk);
      sup <= 1'b0;
      lock <= 1'b0;
      rd_chk("disabled", 4'h0, 8'h00);
      // Four edges of counting after the clearing write see exactly two ticks, then the count freezes.
      rd_chk("count lo", 4'h3, 8'h02);
      rd_chk("count hi", 4'h4, 8'h00);
    end
    // Reset requests of codes 8 and 9 plus the hardware disable are still pending.
    rd_chk("status disable", 4'h1, 8'h06);
    $display("test hardware disable done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_lock;
    t_irq_mode;
    t_reset_mode;
    t_disable;
    results;
  end
  // The tests need about 3100 cycles; sixteen times that means a hang.
  initial begin
    #(20 * 50000);
    error_cnt++;
    results;
  end
endmodule
bind wdt_ctrl wdt_ctrl_monitor #(.P_CNT_WIDTH(P_CNT_WIDTH)) i_wdt_ctrl_monitor (.i_mclk, .i_rst,
  .i_input_clock_tick, .i_instr_done, .i_supply_monitor_event, .i_clock_lock_event, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_sys_reset, .o_download_reset, .o_wdt_irq, .o_irq);
